// ===== verilog/fasr_params.svh
`ifndef FASR_PARAMS_SVH
`define FASR_PARAMS_SVH

// Register indices; byte address is four times the index
`define FASR_ALERT_IDX      4'h5
`define FASR_IRQ_STAT_IDX   4'h6
`define FASR_IRQ_CLR_IDX    4'h7
`define FASR_IRQ_EN_IDX     4'h8
`define FASR_ALERT_RST      16'h0000

// Alert bit positions
`define FASR_B_OSC          15
`define FASR_B_OSC_RED      14
`define FASR_B_UP_SE        13
`define FASR_B_LO_SE        12
`define FASR_B_UP_SE_RED    11
`define FASR_B_LO_SE_RED    10
`define FASR_B_RAIL3        9
`define FASR_B_RAIL1        7
`define FASR_B_GND3         6
`define FASR_B_GND1         4
`define FASR_B_HV_UNDER     3
`define FASR_B_HV_MARGIN    2
`define FASR_B_HV_OVER      1
`define FASR_B_BSW_SUM      0

// Oscillator check timing
`define FASR_CLK_HZ         100000000
`define FASR_SLOW_OSC_HZ    32768
`define FASR_OSC_PERIODS    2
`define FASR_OSC_TOL_PCT    5
`define FASR_OSC_CNT_W      16

`endif

// ===== verilog/fasr_pkg.sv
`include "fasr_params.svh"

package fasr_pkg;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } fasr_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } fasr_ahb_rsp_t;

    typedef struct packed {
        logic        slow_oscillator;
        logic        power_on_reset_alert;
        logic        upper_port_single_ended;
        logic        lower_port_single_ended;
        logic [2:0]  rail_low;
        logic [2:0]  ground_open;
        logic        high_supply_under;
        logic        high_supply_margin_low;
        logic        measurement_active;
        logic        high_supply_over;
        logic [13:0] balance_switch_fault;
        logic [13:0] balance_switch_enable;
        logic        balance_switch_diag_scan_done;
    } fasr_mon_t;

    typedef struct packed {
        logic [15:0]                    alert;
        logic [15:0]                    irq_stat;
        logic [15:0]                    irq_en;
        logic [31:0]                    hrdata;
        logic                           wr_pend;
        logic [3:0]                     wr_idx;
        logic [`FASR_OSC_CNT_W-1:0]     osc_cnt;
        logic                           osc_half;
        logic                           osc_prev;
        logic                           osc_fault;
    } fasr_state_t;

endpackage : fasr_pkg

// ===== verilog/fasr_alert_reg.sv
`timescale 1ns/1ps
`include "fasr_params.svh"

// Summary of operation
// - Slow oscillator off by over 5% sets 15
// - Bit 14 redundant oscillator alert, own latch
// - Oscillator bits clear on zero-write if resolved
// - Upper single-ended sets 13 after reset alert
// - Lower single-ended sets 12 after reset alert
// - Bit 11 upper single-ended, sets anytime
// - Bit 10 lower single-ended, sets anytime
// - Rail lows set 9..7; zero-write clears once resolved
// - Ground opens set 6..4; zero-write clears
// - High supply under sets 3, gated
// - Margin low sets 2 during measurement only
// - High supply over sets 1, gated
// - Bit 0 ORs enabled switch alerts at scan end
// - Bit 0 auto-clears or zero-write clears
// - Register at index 5, resets to zero
module fasr_alert_reg #(
    parameter int OSC_EXP_CYCLES = `FASR_OSC_PERIODS * `FASR_CLK_HZ / `FASR_SLOW_OSC_HZ
) (
    input  wire logic                    hclk,     // Bus clock, also the fast reference
    input  wire logic                    hresetn,  // Asynchronous reset, active low
    input  wire fasr_pkg::fasr_ahb_req_t ahb_req,  // AHB-Lite slave inputs
    output fasr_pkg::fasr_ahb_rsp_t      ahb_rsp,  // AHB-Lite slave outputs
    input  wire fasr_pkg::fasr_mon_t     mon,      // Monitor fault levels
    output logic                         irq       // Level interrupt
);
    import fasr_pkg::*;

    localparam int OSC_TOL = OSC_EXP_CYCLES * `FASR_OSC_TOL_PCT / 100;
    localparam logic [`FASR_OSC_CNT_W-1:0] OSC_LO = `FASR_OSC_CNT_W'(OSC_EXP_CYCLES - OSC_TOL);
    localparam logic [`FASR_OSC_CNT_W-1:0] OSC_HI = `FASR_OSC_CNT_W'(OSC_EXP_CYCLES + OSC_TOL);

    fasr_state_t s_reg;
    fasr_state_t s_next;

    logic        addr_ok;
    logic        rd_req;
    logic        osc_edge;
    logic        wr_alert;
    logic [15:0] clr;
    logic [15:0] clr_ok;
    logic [15:0] set;
    logic [15:0] irq_clr;
    logic        por;
    logic        bsw_any;
    logic [3:0]  req_idx;

    assign por     = mon.power_on_reset_alert;
    assign bsw_any = |(mon.balance_switch_fault & mon.balance_switch_enable);
    assign req_idx = ahb_req.haddr[5:2];
    assign addr_ok = (ahb_req.haddr[31:6] == 26'h0) && (ahb_req.haddr[1:0] == 2'h0);

    always_comb
    begin
        s_next = s_reg;
        rd_req = 1'b0;

        // Period check of the slow oscillator against hclk, every two periods
        osc_edge        = mon.slow_oscillator & ~s_reg.osc_prev;
        s_next.osc_prev = mon.slow_oscillator;
        if (osc_edge)
        begin
            s_next.osc_half = ~s_reg.osc_half;
            if (s_reg.osc_half)
            begin
                s_next.osc_fault = (s_reg.osc_cnt < OSC_LO) || (s_reg.osc_cnt > OSC_HI);
                s_next.osc_cnt   = '0;
            end
            else
            begin
                s_next.osc_cnt = s_reg.osc_cnt + 1'b1;
            end
        end
        else if (s_reg.osc_cnt > OSC_HI)
        begin
            // Stopped or slow oscillator: flag without waiting for an edge
            s_next.osc_fault = 1'b1;
            s_next.osc_cnt   = '0;
            s_next.osc_half  = 1'b0;
        end
        else
        begin
            s_next.osc_cnt = s_reg.osc_cnt + 1'b1;
        end

        // Data phase of a write
        wr_alert = s_reg.wr_pend && (s_reg.wr_idx == `FASR_ALERT_IDX);
        clr      = wr_alert ? ~ahb_req.hwdata[15:0] : 16'h0000;
        irq_clr  = (s_reg.wr_pend && (s_reg.wr_idx == `FASR_IRQ_CLR_IDX)) ? ahb_req.hwdata[15:0] : 16'h0000;
        if (s_reg.wr_pend && (s_reg.wr_idx == `FASR_IRQ_EN_IDX))
        begin
            s_next.irq_en = ahb_req.hwdata[15:0];
        end

        // Set conditions of the latched alerts
        set = 16'h0000;
        set[`FASR_B_OSC]     = s_reg.osc_fault;
        set[`FASR_B_OSC_RED] = s_reg.osc_fault;
        set[`FASR_B_UP_SE]     = mon.upper_port_single_ended & ~por;
        set[`FASR_B_LO_SE]     = mon.lower_port_single_ended & ~por;
        set[`FASR_B_UP_SE_RED] = mon.upper_port_single_ended;
        set[`FASR_B_LO_SE_RED] = mon.lower_port_single_ended;
        set[`FASR_B_RAIL3:`FASR_B_RAIL1] = mon.rail_low & {3{~por}};
        set[`FASR_B_GND3:`FASR_B_GND1]   = mon.ground_open & {3{~por}};
        set[`FASR_B_HV_UNDER]  = mon.high_supply_under & ~por;
        set[`FASR_B_HV_MARGIN] = mon.high_supply_margin_low & mon.measurement_active;
        set[`FASR_B_HV_OVER]   = mon.high_supply_over & ~por;

        // Which bits a zero-write may clear right now
        clr_ok = 16'h0000;
        clr_ok[`FASR_B_OSC]     = ~s_reg.osc_fault;
        clr_ok[`FASR_B_OSC_RED] = ~s_reg.osc_fault;
        clr_ok[`FASR_B_RAIL3:`FASR_B_RAIL1] = ~mon.rail_low;
        clr_ok[`FASR_B_GND3:`FASR_B_GND1]   = 3'b111;
        clr_ok[`FASR_B_HV_UNDER]  = 1'b1;
        clr_ok[`FASR_B_HV_MARGIN] = 1'b1;
        clr_ok[`FASR_B_HV_OVER]   = 1'b1;

        // Set wins over a clear in the same cycle
        s_next.alert[15:1] = set[15:1] | (s_reg.alert[15:1] & ~(clr[15:1] & clr_ok[15:1]));

        // Balance switch summary
        if (mon.balance_switch_diag_scan_done)
        begin
            s_next.alert[`FASR_B_BSW_SUM] = bsw_any;
        end
        else if (!bsw_any || clr[`FASR_B_BSW_SUM])
        begin
            s_next.alert[`FASR_B_BSW_SUM] = 1'b0;
        end

        // Interrupt status: new alerts set, write-one clears, set wins
        s_next.irq_stat = (s_next.alert & ~s_reg.alert) | (s_reg.irq_stat & ~irq_clr);

        // Address phase
        s_next.wr_pend = 1'b0;
        if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready)
        begin
            s_next.wr_pend = ahb_req.hwrite && addr_ok;
            s_next.wr_idx  = req_idx;
            rd_req         = ~ahb_req.hwrite;
        end

        // Read data from the values that stand after this edge
        if (rd_req)
        begin
            s_next.hrdata = 32'h0000_0000;
            if (addr_ok)
            begin
                case (req_idx)
                    `FASR_ALERT_IDX:    s_next.hrdata = {16'h0000, s_next.alert};
                    `FASR_IRQ_STAT_IDX: s_next.hrdata = {16'h0000, s_next.irq_stat};
                    `FASR_IRQ_EN_IDX:   s_next.hrdata = {16'h0000, s_next.irq_en};
                    default:            s_next.hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_reg          <= '0;
            s_reg.alert    <= `FASR_ALERT_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign ahb_rsp = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: s_reg.hrdata};
    assign irq               = |(s_reg.irq_stat & s_reg.irq_en);

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic rd_alert_req;
    assign rd_alert_req = rd_req && addr_ok && (req_idx == `FASR_ALERT_IDX);

    a_osc_set_both: assert property (s_reg.osc_fault |=> s_reg.alert[15] && s_reg.alert[14])
        else $error("oscillator fault did not set both alert bits");

    a_osc_twin_equal: assert property (s_reg.alert[15] == s_reg.alert[14])
        else $error("redundant oscillator alert differs");

    a_osc_clear_blocked: assert property (s_reg.alert[15] && s_reg.osc_fault |=> s_reg.alert[15])
        else $error("oscillator alert cleared while fault present");

    a_por_gates_upper: assert property (!s_reg.alert[13] && por |=> !s_reg.alert[13])
        else $error("upper single-ended alert set before reset alert cleared");

    a_por_gates_lower: assert property (!s_reg.alert[12] && por |=> !s_reg.alert[12])
        else $error("lower single-ended alert set before reset alert cleared");

    a_upper_early: assert property (mon.upper_port_single_ended |=> s_reg.alert[11] [*2])
        else $error("redundant upper single-ended alert missing");

    a_lower_early: assert property (mon.lower_port_single_ended |=> s_reg.alert[10])
        else $error("redundant lower single-ended alert missing");

    a_rail_hold: assert property (s_reg.alert[9] && mon.rail_low[2] |=> s_reg.alert[9])
        else $error("rail alert cleared while rail still low");

    a_gnd_gate: assert property (por && s_reg.alert[6:4] == 3'b000 |=> s_reg.alert[6:4] == 3'b000)
        else $error("ground alert set before reset alert cleared");

    a_margin_only_meas: assert property (!mon.measurement_active && !s_reg.alert[2] |=> !s_reg.alert[2])
        else $error("margin alert set outside measurement");

    a_hv_over_set: assert property (mon.high_supply_over && !por |=> s_reg.alert[1])
        else $error("high supply overvoltage alert not set");

    a_sum_update: assert property (mon.balance_switch_diag_scan_done |=> s_reg.alert[0] == $past(bsw_any))
        else $error("switch summary not updated at scan end");

    a_sum_auto_clear: assert property (!bsw_any && !mon.balance_switch_diag_scan_done |=> !s_reg.alert[0])
        else $error("switch summary not cleared after alerts resolved");

    a_ro_sticky: assert property (s_reg.alert[13:10] != 4'h0 |=> (s_reg.alert[13:10] & $past(s_reg.alert[13:10]))
                                  == $past(s_reg.alert[13:10]))
        else $error("read-only alert bit changed by a write");

    a_rd_alert: assert property (rd_alert_req |=> ahb_rsp.hrdata == {16'h0000, s_reg.alert})
        else $error("alert register read data wrong");

    a_set_beats_clear: assert property (wr_alert && !ahb_req.hwdata[3] && mon.high_supply_under && !por
                                        |=> s_reg.alert[3])
        else $error("clearing write beat a fault in the same cycle");

    a_osc_stop_flag: assert property (!osc_edge && s_reg.osc_cnt > OSC_HI |=> s_reg.osc_fault)
        else $error("stopped slow oscillator not flagged");

    a_osc_eval_cnt: assert property (osc_edge && s_reg.osc_half |=> s_reg.osc_cnt == '0)
        else $error("period counter not restarted after two periods");

    a_osc_hold_between: assert property (!osc_edge && s_reg.osc_cnt <= OSC_HI |=> $stable(s_reg.osc_fault))
        else $error("oscillator verdict changed between evaluations");

    a_osc_red_blocked: assert property (s_reg.alert[14] && s_reg.osc_fault |=> s_reg.alert[14])
        else $error("redundant oscillator alert cleared while fault present");

    a_osc_clear_ok: assert property (wr_alert && !ahb_req.hwdata[15] && !s_reg.osc_fault |=> !s_reg.alert[15])
        else $error("oscillator alert not cleared after fault resolved");

    a_osc_red_clear: assert property (wr_alert && !ahb_req.hwdata[14] && !s_reg.osc_fault |=> !s_reg.alert[14])
        else $error("redundant oscillator alert not cleared after fault resolved");

    a_upper_gated_set: assert property (mon.upper_port_single_ended && !por |=> s_reg.alert[13])
        else $error("upper single-ended alert not set");

    a_lower_gated_set: assert property (mon.lower_port_single_ended && !por |=> s_reg.alert[12])
        else $error("lower single-ended alert not set");

    a_upper_early_hold: assert property (s_reg.alert[11] |=> s_reg.alert[11])
        else $error("redundant upper single-ended alert dropped");

    a_lower_early_hold: assert property (s_reg.alert[10] |=> s_reg.alert[10])
        else $error("redundant lower single-ended alert dropped");

    a_rail1_set: assert property (mon.rail_low[0] && !por |=> s_reg.alert[7])
        else $error("rail one alert not set");

    a_rail2_set: assert property (mon.rail_low[1] && !por |=> s_reg.alert[8])
        else $error("rail two alert not set");

    a_rail3_set: assert property (mon.rail_low[2] && !por |=> s_reg.alert[9])
        else $error("rail three alert not set");

    a_rail_gate: assert property (por && s_reg.alert[9:7] == 3'b000 |=> s_reg.alert[9:7] == 3'b000)
        else $error("rail alert set before reset alert cleared");

    a_rail2_hold: assert property (s_reg.alert[8] && mon.rail_low[1] |=> s_reg.alert[8])
        else $error("rail two alert cleared while rail still low");

    a_rail1_hold: assert property (s_reg.alert[7] && mon.rail_low[0] |=> s_reg.alert[7])
        else $error("rail one alert cleared while rail still low");

    a_rail_clear: assert property (wr_alert && !ahb_req.hwdata[7] && !mon.rail_low[0] |=> !s_reg.alert[7])
        else $error("rail one alert not cleared after resolve");

    a_gnd1_set: assert property (mon.ground_open[0] && !por |=> s_reg.alert[4])
        else $error("ground one alert not set");

    a_gnd2_set: assert property (mon.ground_open[1] && !por |=> s_reg.alert[5])
        else $error("ground two alert not set");

    a_gnd3_set: assert property (mon.ground_open[2] && !por |=> s_reg.alert[6])
        else $error("ground three alert not set");

    a_gnd_clear: assert property (wr_alert && !ahb_req.hwdata[4] && !(mon.ground_open[0] && !por) |=> !s_reg.alert[4])
        else $error("ground one alert not cleared by zero write");

    a_hv_under_set: assert property (mon.high_supply_under && !por |=> s_reg.alert[3])
        else $error("high supply undervoltage alert not set");

    a_hv_under_gate: assert property (por && !s_reg.alert[3] |=> !s_reg.alert[3])
        else $error("undervoltage alert set before reset alert cleared");

    a_hv_under_clear: assert property (wr_alert && !ahb_req.hwdata[3] && !mon.high_supply_under |=> !s_reg.alert[3])
        else $error("undervoltage alert not cleared by zero write");

    a_margin_set: assert property (mon.high_supply_margin_low && mon.measurement_active |=> s_reg.alert[2])
        else $error("margin alert not set during measurement");

    a_margin_clear: assert property (wr_alert && !ahb_req.hwdata[2] && !mon.measurement_active |=> !s_reg.alert[2])
        else $error("margin alert not cleared by zero write");

    a_hv_over_gate: assert property (por && !s_reg.alert[1] |=> !s_reg.alert[1])
        else $error("overvoltage alert set before reset alert cleared");

    a_hv_over_clear: assert property (wr_alert && !ahb_req.hwdata[1] && !mon.high_supply_over |=> !s_reg.alert[1])
        else $error("overvoltage alert not cleared by zero write");

    a_sum_scan_clear: assert property (mon.balance_switch_diag_scan_done && !bsw_any |=> !s_reg.alert[0])
        else $error("switch summary set by scan without alerts");

    a_sum_no_early: assert property (!s_reg.alert[0] && !mon.balance_switch_diag_scan_done |=> !s_reg.alert[0])
        else $error("switch summary set outside scan end");

    a_sum_zero_write: assert property (wr_alert && !ahb_req.hwdata[0] && !mon.balance_switch_diag_scan_done
                                       |=> !s_reg.alert[0])
        else $error("switch summary not cleared by zero write");

    a_sum_hold: assert property (!mon.balance_switch_diag_scan_done && bsw_any && !clr[0] |=> $stable(s_reg.alert[0]))
        else $error("switch summary changed between scans");

    a_ones_ignored: assert property (wr_alert && ahb_req.hwdata[15:1] == 15'h7FFF
                                     |=> s_reg.alert[15:1] == ($past(s_reg.alert[15:1]) | $past(set[15:1])))
        else $error("write of ones changed an alert bit");

    a_rd_stat: assert property (rd_req && addr_ok && req_idx == `FASR_IRQ_STAT_IDX |=> ahb_rsp.hrdata[15:0] == s_reg.irq_stat)
        else $error("interrupt status read data wrong");

    a_rd_en: assert property (rd_req && addr_ok && req_idx == `FASR_IRQ_EN_IDX |=> ahb_rsp.hrdata[15:0] == s_reg.irq_en)
        else $error("interrupt enable read data wrong");

    a_rd_clr_zero: assert property (rd_req && addr_ok && req_idx == `FASR_IRQ_CLR_IDX |=> ahb_rsp.hrdata == 32'h0000_0000)
        else $error("interrupt clear register read not zero");

    a_rd_other: assert property (rd_req && !addr_ok |=> ahb_rsp.hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_hrdata_stands: assert property (!rd_req |=> $stable(ahb_rsp.hrdata))
        else $error("read data changed without a read");

    a_irq_en_write: assert property (s_reg.wr_pend && s_reg.wr_idx == `FASR_IRQ_EN_IDX
                                     |=> s_reg.irq_en == $past(ahb_req.hwdata[15:0]))
        else $error("interrupt enable write lost");

    a_irq_rise: assert property ($rose(s_reg.alert[4]) |-> s_reg.irq_stat[4])
        else $error("interrupt status not set by new alert");

    a_irq_level: assert property (irq == |(s_reg.irq_stat & s_reg.irq_en))
        else $error("interrupt output wrong");

    a_bus_okay: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
        else $error("bus response not ready and okay");

    a_set_beats_gnd: assert property (wr_alert && !ahb_req.hwdata[5] && mon.ground_open[1] && !por |=> s_reg.alert[5])
        else $error("clearing write beat a ground fault");

    c_osc_fault:  cover property (s_reg.osc_fault ##1 s_reg.alert[15]);
    c_sum_set:    cover property (mon.balance_switch_diag_scan_done && bsw_any ##1 s_reg.alert[0]);
    c_irq_raised: cover property (!irq ##1 irq);
    c_rail_clear: cover property (s_reg.alert[7] ##1 !s_reg.alert[7]);
    c_ro_write:   cover property (wr_alert && s_reg.alert[11]);

endmodule : fasr_alert_reg

// ===== testbench/tb.sv
`timescale 1ns/1ps
`include "fasr_params.svh"

module tb;
    import fasr_pkg::*;

    localparam logic [31:0] A_ALERT = 32'({`FASR_ALERT_IDX, 2'b00});
    localparam logic [31:0] A_STAT  = 32'({`FASR_IRQ_STAT_IDX, 2'b00});
    localparam logic [31:0] A_CLR   = 32'({`FASR_IRQ_CLR_IDX, 2'b00});
    localparam logic [31:0] A_EN    = 32'({`FASR_IRQ_EN_IDX, 2'b00});
    localparam logic [31:0] A_NONE  = 32'h0000_0040;

    logic          hclk = 1'b0;
    logic          hresetn = 1'b0;
    fasr_ahb_req_t req;
    fasr_ahb_req_t bus;
    fasr_ahb_rsp_t rsp;
    fasr_mon_t     mon;
    logic          irq;
    int            fails = 0;
    int            n_checks = 0;
    int            cyc = 0;
    int            osc_half = 25;

    always #5 hclk = ~hclk;

    // Bus ready loops back from the one slave
    always_comb
    begin
        bus = req;
        bus.hready = rsp.hreadyout;
    end

    fasr_alert_reg #(.OSC_EXP_CYCLES(100)) dut (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ahb_req (bus),
        .ahb_rsp (rsp),
        .mon     (mon),
        .irq     (irq)
    );

    // Slow oscillator: 2 periods of 2*osc_half cycles; 25 gives a count of 99 against the expected 100
    always
    begin
        repeat (osc_half) @(posedge hclk);
        mon.slow_oscillator <= ~mon.slow_oscillator;
    end

    task results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            results();
        end
    end

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        req.hsel   <= 1'b1;
        req.htrans <= 2'b10;
        req.haddr  <= a;
        req.hwrite <= w;
        req.hsize  <= 3'b010;
        @(posedge hclk);
        while (rsp.hreadyout !== 1'b1) @(posedge hclk);
        req.htrans <= 2'b00;
        req.hsel   <= 1'b0;
        req.hwdata <= d;
        @(posedge hclk);
        while (rsp.hreadyout !== 1'b1) @(posedge hclk);
        r = rsp.hrdata;
    endtask : xfer

    task wr(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] r;
        xfer(1'b1, a, {16'h0000, d}, r);
    endtask : wr

    task rd(input string name, input logic [31:0] a, input logic [15:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        chk(name, {16'h0000, exp}, r);
    endtask : rd

    task scan;
        mon.balance_switch_diag_scan_done <= 1'b1;
        @(posedge hclk);
        mon.balance_switch_diag_scan_done <= 1'b0;
        tick(3);
    endtask : scan

    initial
    begin
        req = '0;
        mon = '0;
        tick(6);
        hresetn <= 1'b1;
        tick(2);
        rd("alert reset", A_ALERT, `FASR_ALERT_RST);
        chk("irq reset", 32'(1'b0), 32'(irq));
        tick(300);
        wr(A_ALERT, 16'h0000);
        wr(A_CLR, 16'hFFFF);
        // Every monitor but the slow oscillator and the balance switches faulting while the reset alert is still pending
        mon.power_on_reset_alert <= 1'b1;
        mon.upper_port_single_ended <= 1'b1;
        mon.lower_port_single_ended <= 1'b1;
        mon.rail_low <= 3'b111;
        mon.ground_open <= 3'b111;
        mon.high_supply_under <= 1'b1;
        mon.high_supply_over <= 1'b1;
        mon.high_supply_margin_low <= 1'b1;
        tick(5);
        rd("alert gated", A_ALERT, 16'h0C00);
        mon.power_on_reset_alert <= 1'b0;
        tick(5);
        rd("alert ungated", A_ALERT, 16'h3FFA);
        wr(A_ALERT, 16'h0000);
        wr(A_ALERT, 16'hFFFF);
        rd("alert set wins", A_ALERT, 16'h3FFA);
        // Interrupt status, enable, clear and an unmapped place
        rd("irq status", A_STAT, 16'h3FFA);
        chk("irq masked", 32'(1'b0), 32'(irq));
        wr(A_EN, 16'h0010);
        tick(2);
        chk("irq raised", 32'(1'b1), 32'(irq));
        rd("irq enable", A_EN, 16'h0010);
        chk("hresp okay", 32'(1'b0), 32'(rsp.hresp));
        wr(A_STAT, 16'h0000);
        rd("irq status ro", A_STAT, 16'h3FFA);
        wr(A_CLR, 16'h0010);
        tick(2);
        chk("irq cleared", 32'(1'b0), 32'(irq));
        rd("unmapped", A_NONE, 16'h0000);
        // Conditions resolve; zero-write clears all but the read-only bits
        mon.upper_port_single_ended <= 1'b0;
        mon.lower_port_single_ended <= 1'b0;
        mon.rail_low <= 3'b000;
        mon.ground_open <= 3'b000;
        mon.high_supply_under <= 1'b0;
        mon.high_supply_over <= 1'b0;
        mon.high_supply_margin_low <= 1'b0;
        tick(2);
        wr(A_ALERT, 16'h0000);
        rd("alert resolved", A_ALERT, 16'h3C00);
        mon.high_supply_margin_low <= 1'b1;
        mon.measurement_active <= 1'b1;
        tick(5);
        rd("margin", A_ALERT, 16'h3C04);
        mon.high_supply_margin_low <= 1'b0;
        mon.measurement_active <= 1'b0;
        wr(A_ALERT, 16'h0000);
        rd("margin clear", A_ALERT, 16'h3C00);
        // Balance switch summary
        mon.balance_switch_fault <= 14'h0004;
        mon.balance_switch_enable <= 14'h3FFF;
        tick(3);
        rd("summary before scan", A_ALERT, 16'h3C00);
        scan();
        rd("summary", A_ALERT, 16'h3C01);
        mon.balance_switch_fault <= 14'h0000;
        tick(3);
        rd("summary auto", A_ALERT, 16'h3C00);
        mon.balance_switch_fault <= 14'h2000;
        mon.balance_switch_enable <= 14'h1FFF;
        scan();
        rd("summary disabled", A_ALERT, 16'h3C00);
        mon.balance_switch_enable <= 14'h3FFF;
        scan();
        rd("summary top", A_ALERT, 16'h3C01);
        wr(A_ALERT, 16'h0000);
        rd("summary write", A_ALERT, 16'h3C00);
        // Slow oscillator far off rate, then back
        osc_half = 70;
        tick(400);
        rd("osc fault", A_ALERT, 16'hFC00);
        wr(A_ALERT, 16'h0000);
        rd("osc held", A_ALERT, 16'hFC00);
        osc_half = 25;
        tick(400);
        wr(A_ALERT, 16'h0000);
        rd("osc cleared", A_ALERT, 16'h3C00);
        results();
    end
endmodule : tb
